// *** rtl/stereo_adc_pkg.sv ***
// Purpose: Shared constants and types for the stereo ADC serial port
// Assumes: One master clock domain, sample pairs of two 16-bit words
// Notes: Divide select codes are {high, low}
package stereo_adc_pkg;
  localparam int WORD_BITS = 16;
  localparam int FRAME_TICKS = 128;
  localparam int BUF_DEPTH = 2;
  localparam logic [6:0] FRAME_CNT_RESET = 7'h00;
  localparam logic [4:0] BIT_POS_DATA_END = 5'h10;
  localparam logic [4:0] BIT_POS_MAX = 5'h1f;
  localparam logic [1:0] DIV_CNT_RESET = 2'h0;

  typedef enum logic [1:0] {
    DIV_POWER_DOWN = 2'b00,
    DIV_BY_ONE = 2'b01,
    DIV_BY_TWO = 2'b10,
    DIV_BY_THREE = 2'b11
  } div_sel_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] left;
    logic [WORD_BITS-1:0] right;
  } stereo_pair_t;
endpackage

// *** rtl/stereo_adc_serial_port.sv ***
// Purpose: Clock division and serial output port of a stereo audio ADC
// Assumes: All inputs synchronous to CLOCK_I except slave frame/bit clock
// Notes: Converter results enter through a two-entry buffer
// Operation
// - Sample clock is master clock over 1/2/3.
// - One stereo frame per 128 sample clocks.
// - Frame sync and bit clock are bidirectional.
// - Frame sync realigns transmitter and dividers.
// - Left while sync high, right while low.
// - Data changes on bit clock rising edge.
// - Slave bit clock resampled by sample clock.
// - MSB first, left word before right.
// - Slave inputs sampled on master clock rise.
// - Slave select low drives, high receives.
// - Divide code zero means power down.
module stereo_adc_serial_port #(
  parameter int DEPTH = stereo_adc_pkg::BUF_DEPTH
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic CLOCK_DIVIDE_SELECT_LOW_I,
  input wire logic CLOCK_DIVIDE_SELECT_HIGH_I,
  input wire logic SLAVE_SELECT_INPUT_I,
  input wire logic SAMPLE_VALID_I,
  input wire stereo_adc_pkg::stereo_pair_t SAMPLE_I,
  output logic SAMPLE_READY_O,
  input wire logic FRAME_SYNC_I,
  output logic FRAME_SYNC_O,
  output logic FRAME_SYNC_OE_O,
  input wire logic BIT_CLOCK_I,
  output logic BIT_CLOCK_O,
  output logic BIT_CLOCK_OE_O,
  output logic SERIAL_DATA_OUT_O,
  output logic SAMPLE_TICK_O,
  output logic POWER_DOWN_O
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  stereo_adc_pkg::div_sel_t div_sel;
  logic power_down, slave;
  logic [1:0] div_last, div_cnt_r;
  logic tick_r;
  logic [6:0] frame_cnt_r;
  logic bclk_s1_r, bclk_s2_r, fs_s1_r, fs_s2_r, fs_s3_r;
  logic bclk_c_r, fs_c_r;
  logic fs_edge_raw, bclk_rise, half_start, fs_lvl;
  logic [stereo_adc_pkg::WORD_BITS-1:0] sh_r, cur_word;
  logic [4:0] pos_r, cur_pos;
  logic chan_left_r;
  stereo_adc_pkg::stereo_pair_t buf_mem [DEPTH];
  stereo_adc_pkg::stereo_pair_t out_pair_r;
  logic [PTR_W-1:0] wr_ptr_r, rd_ptr_r;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic push, pop;

  assign div_sel = stereo_adc_pkg::div_sel_t'({CLOCK_DIVIDE_SELECT_HIGH_I,
                                              CLOCK_DIVIDE_SELECT_LOW_I});
  assign power_down = (div_sel == stereo_adc_pkg::DIV_POWER_DOWN);
  assign slave = SLAVE_SELECT_INPUT_I;

  always_comb begin
    unique case (div_sel)
      stereo_adc_pkg::DIV_BY_TWO: div_last = 2'h1;
      stereo_adc_pkg::DIV_BY_THREE: div_last = 2'h2;
      default: div_last = 2'h0;
    endcase
  end

  // Two flops for bit clock, three for frame sync; the sync realign edge uses the second and third
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      fs_s1_r <= 1'b0;
      fs_s2_r <= 1'b0;
      fs_s3_r <= 1'b0;
    end else begin
      bclk_s1_r <= BIT_CLOCK_I;
      bclk_s2_r <= bclk_s1_r;
      fs_s1_r <= FRAME_SYNC_I;
      fs_s2_r <= fs_s1_r;
      fs_s3_r <= fs_s2_r;
    end
  end

  assign fs_edge_raw = slave && (fs_s2_r != fs_s3_r);

  // Sample clock divider, restarted by a slave frame sync edge
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      div_cnt_r <= stereo_adc_pkg::DIV_CNT_RESET;
      tick_r <= 1'b0;
    end else if (power_down) begin
      div_cnt_r <= stereo_adc_pkg::DIV_CNT_RESET;
      tick_r <= 1'b0;
    end else if (fs_edge_raw) begin
      div_cnt_r <= stereo_adc_pkg::DIV_CNT_RESET;
      tick_r <= 1'b0;
    end else if (div_cnt_r >= div_last) begin
      div_cnt_r <= stereo_adc_pkg::DIV_CNT_RESET;
      tick_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 2'h1;
      tick_r <= 1'b0;
    end
  end

  // Frame position; 7 bits wrap at 128 ticks
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      frame_cnt_r <= stereo_adc_pkg::FRAME_CNT_RESET;
    end else if (power_down || (fs_edge_raw && fs_s2_r)) begin
      frame_cnt_r <= stereo_adc_pkg::FRAME_CNT_RESET;
    end else if (tick_r) begin
      frame_cnt_r <= frame_cnt_r + 7'h01;
    end
  end

  // Slave clocks resampled on the sample clock to keep data edges quiet
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bclk_c_r <= 1'b0;
      fs_c_r <= 1'b0;
    end else if (tick_r) begin
      bclk_c_r <= bclk_s2_r;
      fs_c_r <= fs_s2_r;
    end
  end

  always_comb begin
    if (slave) begin
      bclk_rise = tick_r && bclk_s2_r && !bclk_c_r;
      half_start = tick_r && (fs_s2_r != fs_c_r);
      fs_lvl = fs_s2_r;
    end else begin
      bclk_rise = tick_r && frame_cnt_r[0];
      half_start = tick_r && (frame_cnt_r[5:0] == 6'h00);
      fs_lvl = !frame_cnt_r[6];
    end
  end

  // Master pins: bit clock is two ticks, sync high for the left half
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      BIT_CLOCK_O <= 1'b0;
      FRAME_SYNC_O <= 1'b0;
      BIT_CLOCK_OE_O <= 1'b0;
      FRAME_SYNC_OE_O <= 1'b0;
    end else begin
      BIT_CLOCK_OE_O <= !slave;
      FRAME_SYNC_OE_O <= !slave;
      if (slave || power_down) begin
        BIT_CLOCK_O <= 1'b0;
        FRAME_SYNC_O <= 1'b0;
      end else if (tick_r) begin
        BIT_CLOCK_O <= frame_cnt_r[0];
        FRAME_SYNC_O <= !frame_cnt_r[6];
      end
    end
  end

  always_comb begin
    if (half_start) begin
      cur_pos = 5'h00;
      if (!fs_lvl) cur_word = out_pair_r.right;
      else if (count_r != '0) cur_word = buf_mem[rd_ptr_r].left;
      else cur_word = out_pair_r.left;
    end else begin
      cur_pos = pos_r;
      cur_word = sh_r;
    end
  end

  // Word shifter; zeros fill the unused bit slots of each half
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sh_r <= '0;
      pos_r <= stereo_adc_pkg::BIT_POS_MAX;
      SERIAL_DATA_OUT_O <= 1'b0;
      chan_left_r <= 1'b0;
    end else if (power_down) begin
      pos_r <= stereo_adc_pkg::BIT_POS_MAX;
      SERIAL_DATA_OUT_O <= 1'b0;
    end else begin
      if (half_start) chan_left_r <= fs_lvl;
      if (bclk_rise) begin
        SERIAL_DATA_OUT_O <= (cur_pos < stereo_adc_pkg::BIT_POS_DATA_END)
                             && cur_word[stereo_adc_pkg::WORD_BITS-1];
        sh_r <= {cur_word[stereo_adc_pkg::WORD_BITS-2:0], 1'b0};
        if (cur_pos != stereo_adc_pkg::BIT_POS_MAX) pos_r <= cur_pos + 5'h01;
        else pos_r <= cur_pos;
      end else if (half_start) begin
        sh_r <= cur_word;
        pos_r <= cur_pos;
      end
    end
  end

  // Buffer: a left half start takes a new pair only if one is waiting, else repeats the last
  assign push = SAMPLE_VALID_I && SAMPLE_READY_O;
  assign pop = half_start && fs_lvl && (count_r != '0);
  assign count_nxt = count_r + CNT_W'(push) - CNT_W'(pop);

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      SAMPLE_READY_O <= 1'b0;
      out_pair_r <= '0;
    end else begin
      count_r <= count_nxt;
      SAMPLE_READY_O <= (count_nxt != CNT_W'(DEPTH));
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        out_pair_r <= buf_mem[rd_ptr_r];
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Storage needs no reset; only entries behind count are read
  always_ff @(posedge CLOCK_I) begin
    if (push) buf_mem[wr_ptr_r] <= SAMPLE_I;
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      SAMPLE_TICK_O <= 1'b0;
      POWER_DOWN_O <= 1'b0;
    end else begin
      SAMPLE_TICK_O <= tick_r;
      POWER_DOWN_O <= power_down;
    end
  end

  // Helper: ticks between master frame sync rises
  logic [7:0] gap_cnt_r;
  logic gap_seen_r;
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      gap_cnt_r <= 8'h00;
      gap_seen_r <= 1'b0;
    end else if (slave || power_down) begin
      gap_cnt_r <= 8'h00;
      gap_seen_r <= 1'b0;
    end else if (tick_r && frame_cnt_r == 7'h00) begin
      gap_cnt_r <= 8'h01;
      gap_seen_r <= 1'b1;
    end else if (tick_r) begin
      gap_cnt_r <= gap_cnt_r + 8'h01;
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);

  div_three_a: assert property (tick_r && div_sel ==
      stereo_adc_pkg::DIV_BY_THREE && !slave && $stable(div_sel)
      |=> !tick_r [*2] ##1 (tick_r || slave || div_sel !=
      stereo_adc_pkg::DIV_BY_THREE))
    else $error("divide by three tick spacing wrong");
  frame_len_a: assert property (gap_seen_r && tick_r &&
      frame_cnt_r == 7'h00 |-> gap_cnt_r == 8'(stereo_adc_pkg::FRAME_TICKS))
    else $error("master frame not 128 sample clocks");
  oe_pair_a: assert property (BIT_CLOCK_OE_O == FRAME_SYNC_OE_O)
    else $error("pin directions disagree");
  slave_hiz_a: assert property (slave |=> !BIT_CLOCK_OE_O
      && !FRAME_SYNC_OE_O)
    else $error("pins driven in slave mode");
  fs_realign_a: assert property (fs_edge_raw && !power_down
      |=> div_cnt_r == stereo_adc_pkg::DIV_CNT_RESET && !tick_r)
    else $error("frame sync did not realign divider");
  chan_lvl_a: assert property (half_start && !power_down
      |=> chan_left_r == $past(fs_lvl))
    else $error("channel not taken from frame sync level");
  sdo_edge_a: assert property ($changed(SERIAL_DATA_OUT_O)
      && !POWER_DOWN_O |-> $past(bclk_rise) || $past(power_down))
    else $error("data changed away from bit clock rise");
  msb_first_a: assert property (bclk_rise && !half_start &&
      !power_down && pos_r < stereo_adc_pkg::BIT_POS_DATA_END
      |=> SERIAL_DATA_OUT_O == $past(sh_r[stereo_adc_pkg::WORD_BITS-1]))
    else $error("data bit order wrong");
  resample_a: assert property ($past(slave) && !POWER_DOWN_O &&
      $changed(SERIAL_DATA_OUT_O) |-> $past(tick_r && bclk_s2_r))
    else $error("bit clock used off the sample clock");
  pd_tick_a: assert property (power_down |=> !tick_r)
    else $error("sample clock runs in power down");

  master_frame_c: cover property (!slave && gap_seen_r && tick_r
      && frame_cnt_r == 7'h00);
  slave_frame_c: cover property (slave && half_start && fs_lvl);
  buf_full_c: cover property (count_r == CNT_W'(DEPTH));
  pd_c: cover property (POWER_DOWN_O);
endmodule

// *** tb/audio_frame_receiver.sv ***
// Purpose: Far-side serial receiver, clock source in slave mode
// Assumes: Shares the master clock with the port
// Notes: Bit taken lag_i clocks after each of the first 16 bit clock rises of a half
module audio_frame_receiver (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slave_i,
  input wire logic sync_i,
  input wire logic bclk_i,
  input wire logic data_i,
  input wire logic [3:0] lag_i,
  output logic sync_o,
  output logic bclk_o,
  output stereo_adc_pkg::stereo_pair_t pair_o,
  output int pairs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] gen_r;
  logic [3:0] wait_r;
  logic [4:0] bits_r;
  logic [15:0] word_r;
  logic bclk_q, chan_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen_r <= 9'h000;
      sync_o <= 1'b0;
      bclk_o <= 1'b0;
    end else if (slave_i) begin
      // 384 clocks is 128 ticks at divide by three
      gen_r <= (gen_r == 9'h17f) ? 9'h000 : gen_r + 9'h001;
      sync_o <= gen_r < 9'h0c0;
      bclk_o <= (gen_r % 9'h00c) >= 9'h006;
    end else begin
      // Released: toggle so no stale level is mistaken for a drive
      sync_o <= ~sync_o;
      bclk_o <= ~bclk_o;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bclk_q <= 1'b0;
      wait_r <= 4'h0;
      bits_r <= 5'h00;
      chan_r <= 1'b0;
      word_r <= 16'h0000;
      pair_o <= '0;
      pairs_o <= 0;
    end else begin
      bclk_q <= bclk_i;
      if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end
      if (bclk_i && !bclk_q) begin
        wait_r <= lag_i;
        chan_r <= sync_i;
        if (sync_i != chan_r) begin
          bits_r <= 5'h00;
        end
      end
      if (wait_r == 4'h1 && bits_r < 5'h10) begin
        word_r <= {word_r[14:0], data_i};
        bits_r <= bits_r + 5'h01;
        if (bits_r == 5'h0f && chan_r) begin
          pair_o.left <= {word_r[14:0], data_i};
        end
        if (bits_r == 5'h0f && !chan_r) begin
          pair_o.right <= {word_r[14:0], data_i};
          pairs_o <= pairs_o + 1;
        end
      end
    end
  end
endmodule

// *** tb/stereo_adc_serial_port_test.sv ***
// Purpose: Self-checking bench for the stereo ADC serial port
// Assumes: 50 MHz master clock, partner receiver on the link
// Notes: Slave runs use divide by three to fit 16 bits a half
module stereo_adc_serial_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slave = 1'b0;
  logic valid = 1'b0;
  logic [1:0] sel = 2'h1;
  logic [3:0] lag = 4'h1;
  stereo_adc_pkg::stereo_pair_t smp = '0;
  stereo_adc_pkg::stereo_pair_t got;
  logic rdy, fs, fs_oe, bc, bc_oe, ser_data, tick, pdn, fs_p, bc_p;
  int pairs;
  int n_fail = 0;
  int checked = 0;
  wire fs_w = fs_oe ? fs : fs_p;
  wire bc_w = bc_oe ? bc : bc_p;
  always #10 clk = ~clk;
  stereo_adc_serial_port i_dut (.CLOCK_I(clk), .RESET_N_I(rst_n),
    .CLOCK_DIVIDE_SELECT_LOW_I(sel[0]),
    .CLOCK_DIVIDE_SELECT_HIGH_I(sel[1]), .SLAVE_SELECT_INPUT_I(slave),
    .SAMPLE_VALID_I(valid), .SAMPLE_I(smp), .SAMPLE_READY_O(rdy),
    .FRAME_SYNC_I(fs_w), .FRAME_SYNC_O(fs), .FRAME_SYNC_OE_O(fs_oe),
    .BIT_CLOCK_I(bc_w), .BIT_CLOCK_O(bc), .BIT_CLOCK_OE_O(bc_oe),
    .SERIAL_DATA_OUT_O(ser_data), .SAMPLE_TICK_O(tick),
    .POWER_DOWN_O(pdn));
  audio_frame_receiver i_rx (.clk_i(clk), .rst_n_i(rst_n),
    .slave_i(slave), .sync_i(fs_w), .bclk_i(bc_w), .data_i(ser_data),
    .lag_i(lag), .sync_o(fs_p), .bclk_o(bc_p), .pair_o(got),
    .pairs_o(pairs));
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic s, input logic [1:0] d);
    rst_n = 1'b0;
    slave = s;
    sel = d;
    valid = 1'b0;
    step(3);
    rst_n = 1'b1;
    step(2);
  endtask
  function automatic logic sig(input int k);
    return (k == 1) ? fs : bc;
  endfunction
  // Clocks from one rise of the chosen output to the next
  task automatic gap(input int k, output int n);
    int i, ph;
    n = 0;
    ph = 0;
    for (i = 0; i < 1600 && ph < 4; i++) begin
      if (sig(k) === ph[0]) ph++;
      else begin
        step(1);
        if (ph >= 2) n++;
      end
    end
    // A search that ran out must not pass as a short period
    if (ph != 4) n = 0;
  endtask
  task automatic send(input logic [31:0] p);
    int i;
    valid = 1'b1;
    smp = p;
    for (i = 0; i < 2000 && rdy !== 1'b1; i++) step(1);
    check("ready", 32'h1, 32'(rdy));
    step(1);
  endtask
  task automatic expect_pair(input logic [31:0] p, input int tries);
    int t, i, c;
    for (t = 0; t < tries; t++) begin
      c = pairs;
      for (i = 0; i < 1000 && pairs == c; i++) step(1);
      check("pairs", 32'(c + 1), 32'(pairs));
      if (got === p) break;
    end
    check("pair", p, got);
  endtask
  task automatic test_divide();
    int d, n, i;
    for (d = 1; d <= 3; d++) begin
      do_reset(1'b0, d[1:0]);
      check("oe", 32'h3, 32'({fs_oe, bc_oe}));
      n = 0;
      for (i = 0; i < 384; i++) begin
        n += 32'(tick);
        step(1);
      end
      check("ticks", 384 / d, n);
      gap(1, n);
      check("frame", 128 * d, n);
      gap(2, n);
      check("bclk", 2 * d, n);
    end
    $display("test_divide done");
  endtask
  task automatic test_power();
    int i, n;
    do_reset(1'b0, 2'b00);
    n = 0;
    for (i = 0; i < 200; i++) begin
      if ({tick, bc} !== 2'b00) n++;
      step(1);
    end
    check("pdn", 32'h1, 32'(pdn));
    check("idle", 0, n);
    sel = 2'b01;
    step(4);
    check("pdn off", 32'h0, 32'(pdn));
    gap(1, n);
    check("frame", 128, n);
    $display("test_power done");
  endtask
  task automatic test_master();
    do_reset(1'b0, 2'b01);
    lag = 4'h1;
    send(32'hc35a_0ff1);
    send(32'h1e87_a5b4);
    check("full", 32'h0, 32'(rdy));
    // Third offer stays up until a left half frees a slot
    send(32'h5555_aaaa);
    valid = 1'b0;
    expect_pair(32'hc35a_0ff1, 4);
    expect_pair(32'h1e87_a5b4, 1);
    expect_pair(32'h5555_aaaa, 1);
    expect_pair(32'h5555_aaaa, 1);
    $display("test_master done");
  endtask
  task automatic test_slave();
    do_reset(1'b1, 2'b11);
    lag = 4'ha;
    check("oe", 32'h0, 32'({fs_oe, bc_oe}));
    send(32'h9abc_1357);
    valid = 1'b0;
    expect_pair(32'h9abc_1357, 5);
    expect_pair(32'h9abc_1357, 1);
    $display("test_slave done");
  endtask
  task automatic conclude();
    $display("Checks %0d, failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    test_divide();
    test_power();
    test_master();
    test_slave();
    conclude();
  end
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
endmodule
